// [hdl/dbc_pkg.sv]
// Package: command encodings, bank states, power states and timing constants.
`default_nettype none
package dbc_pkg;
    localparam int NUM_BANKS = 8;
    localparam int BA_W = 3;
    localparam int CNT_W = 16;
    localparam int CLK_PERIOD_PS = 5000;
    // Timing values in ns, plain defaults; counts are cycles rounded up
    localparam int T_PAGE_CLOSE_NS = 15;
    localparam int T_ACT_TO_COL_NS = 15;
    localparam int T_WRITE_RECOVER_NS = 10;
    localparam int T_WRITE_AUTOCLOSE_RECOVER_NS = 25;
    localparam int T_REFRESH_CYCLE_NS = 60;
    localparam int T_MODE_SET_RECOVER_NS = 10;
    localparam int T_POWERDOWN_EXIT_NS = 10;
    localparam int T_LOCK_NS = 1000;
    localparam int BURST_LEN = 4;
    function automatic logic [CNT_W-1:0] ns2cyc(input int ns);
        int c;
        c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        if (c < 1) begin
            c = 1;
        end
        return c[CNT_W-1:0];
    endfunction
    localparam logic [CNT_W-1:0] C_PAGE_CLOSE = ns2cyc(T_PAGE_CLOSE_NS);
    localparam logic [CNT_W-1:0] C_ACT_TO_COL = ns2cyc(T_ACT_TO_COL_NS);
    localparam logic [CNT_W-1:0] C_WRITE_RECOVER = ns2cyc(T_WRITE_RECOVER_NS);
    localparam logic [CNT_W-1:0] C_WRITE_AC_RECOVER = ns2cyc(T_WRITE_AUTOCLOSE_RECOVER_NS);
    localparam logic [CNT_W-1:0] C_REFRESH_CYCLE = ns2cyc(T_REFRESH_CYCLE_NS);
    localparam logic [CNT_W-1:0] C_MODE_SET_RECOVER = ns2cyc(T_MODE_SET_RECOVER_NS);
    localparam logic [CNT_W-1:0] C_POWERDOWN_EXIT = ns2cyc(T_POWERDOWN_EXIT_NS);
    localparam logic [CNT_W-1:0] C_LOCK = ns2cyc(T_LOCK_NS);
    localparam logic [CNT_W-1:0] C_BURST = CNT_W'(BURST_LEN / 2);
    localparam logic [CNT_W-1:0] C_ONE = 16'h0001;
    localparam logic [CNT_W-1:0] C_ZERO = 16'h0000;

    // Decoded command at one rising edge
    typedef enum logic [3:0] {
        DBC_CMD_DESELECT = 4'h0,
        DBC_CMD_NOP = 4'h1,
        DBC_CMD_RESERVED = 4'h2,
        DBC_CMD_READ = 4'h3,
        DBC_CMD_WRITE = 4'h4,
        DBC_CMD_ACTIVATE = 4'h5,
        DBC_CMD_PAGE_CLOSE = 4'h6,
        DBC_CMD_REFRESH = 4'h7,
        DBC_CMD_MODE_SET = 4'h8
    } dbc_cmd_t;

    typedef enum logic [8:0] {
        DBC_B_IDLE = 9'h001,
        DBC_B_ACTIVATING = 9'h002,
        DBC_B_ACTIVE = 9'h004,
        DBC_B_READ = 9'h008,
        DBC_B_WRITE = 9'h010,
        DBC_B_WRITE_RECOVER = 9'h020,
        DBC_B_WRITE_AC_RECOVER = 9'h040,
        DBC_B_PAGE_CLOSING = 9'h080,
        DBC_B_READ_AC = 9'h100
    } dbc_bank_state_t;

    typedef enum logic [6:0] {
        DBC_P_NORMAL = 7'h01,
        DBC_P_REFRESHING = 7'h02,
        DBC_P_MODE_SETTING = 7'h04,
        DBC_P_POWER_DOWN = 7'h08,
        DBC_P_PD_EXIT = 7'h10,
        DBC_P_SELF_REFRESH = 7'h20,
        DBC_P_SR_RECOVERY = 7'h40
    } dbc_pwr_state_t;

    // Command pins; the strobes are active-low as on the device, auto_close and bank_addr are not
    typedef struct packed {
        logic power_down_n;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic auto_close;
        logic [BA_W-1:0] bank_addr;
    } dbc_cmd_pins_t;
endpackage
`default_nettype wire

// [hdl/dbc_bank_fsm.sv]
// Bank command and power-state machine of an eight-bank double-data-rate memory.
// What this block does
// - Page closing: no-operation idles after t_page_close; closes act as no-operation.
// - Activating: no-operation reaches active after t_act_to_col; all else illegal.
// - Write recovery: no-operation returns active after t_write_recover; others but a write illegal.
// - Write recovery accepts a new write; its auto_close decides closing after burst.
// - Write recovery with auto-close idles after t_write_autoclose_recover; others illegal.
// - Refreshing: only no-operation allowed; idle after t_refresh_cycle.
// - Mode setting: only no-operation allowed; idle after t_mode_set_recover.
// - All-bank page close acts on every bank.
// - Illegality is judged per bank: against the addressed bank's state, and against every bank for refresh, mode set and all-bank close.
// - During auto-close recovery, commands to other banks may be legal.
// - Self-refresh holds while low; exit goes through recovery, idle after t_lock.
// - Power-down holds while low; exit with no-operation, idle after t_powerdown_exit.
// - All idle: low with no-operation enters power-down, with refresh self-refresh.
// - Commands are latched on the rising edge of the true master clock.
// - Data moves on both clock edges, two words per period.
// - Page close: auto_close high closes all banks, low closes the addressed bank.
// - Read or write with auto_close closes the bank at the end of the burst.
`default_nettype none
module dbc_bank_fsm (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire dbc_pkg::dbc_cmd_pins_t cmd_pins_in,
    output logic [dbc_pkg::NUM_BANKS-1:0] bank_idle_out,
    output logic [dbc_pkg::NUM_BANKS-1:0] bank_open_out,
    output logic [dbc_pkg::NUM_BANKS-1:0] bank_burst_out,
    output logic all_idle_out,
    output logic power_down_out,
    output logic self_refresh_out,
    output logic dq_both_edges_out,
    output logic illegal_out
);
    // Pins from the memory controller: two flops before any decode
    dbc_pkg::dbc_cmd_pins_t pin_meta_q;
    dbc_pkg::dbc_cmd_pins_t pin_q;
    logic pd_prev_q;
    dbc_pkg::dbc_cmd_t cmd_d;
    dbc_pkg::dbc_bank_state_t bst_q [dbc_pkg::NUM_BANKS];
    logic [dbc_pkg::CNT_W-1:0] bcnt_q [dbc_pkg::NUM_BANKS];
    dbc_pkg::dbc_pwr_state_t pst_q;
    logic [dbc_pkg::CNT_W-1:0] pcnt_q;
    logic [dbc_pkg::NUM_BANKS-1:0] idle_d;
    logic [dbc_pkg::NUM_BANKS-1:0] burst_d;
    logic [dbc_pkg::NUM_BANKS-1:0] bank_bad_d;
    logic all_idle_d;
    logic normal_d;
    logic pwr_bad_d;
    logic is_nop;
    logic [dbc_pkg::NUM_BANKS-1:0] wr_ac_q;

    always_ff @(posedge core_clk_in) begin
        pin_meta_q <= cmd_pins_in;
        pin_q <= pin_meta_q;
        pd_prev_q <= pin_q.power_down_n;
    end

    always_comb begin
        if (pin_q.cs_n) begin
            cmd_d = dbc_pkg::DBC_CMD_DESELECT;
        end else begin
            case ({pin_q.ras_n, pin_q.cas_n, pin_q.we_n})
                3'h7: cmd_d = dbc_pkg::DBC_CMD_NOP;
                3'h6: cmd_d = dbc_pkg::DBC_CMD_RESERVED;
                3'h5: cmd_d = dbc_pkg::DBC_CMD_READ;
                3'h4: cmd_d = dbc_pkg::DBC_CMD_WRITE;
                3'h3: cmd_d = dbc_pkg::DBC_CMD_ACTIVATE;
                3'h2: cmd_d = dbc_pkg::DBC_CMD_PAGE_CLOSE;
                3'h1: cmd_d = dbc_pkg::DBC_CMD_REFRESH;
                default: cmd_d = dbc_pkg::DBC_CMD_MODE_SET;
            endcase
        end
    end

    assign is_nop = (cmd_d == dbc_pkg::DBC_CMD_DESELECT) || (cmd_d == dbc_pkg::DBC_CMD_NOP);
    assign normal_d = (pst_q == dbc_pkg::DBC_P_NORMAL) && pd_prev_q && pin_q.power_down_n;

    always_comb begin
        for (int i = 0; i < dbc_pkg::NUM_BANKS; i++) begin
            idle_d[i] = (bst_q[i] == dbc_pkg::DBC_B_IDLE);
            burst_d[i] = (bst_q[i] == dbc_pkg::DBC_B_READ) || (bst_q[i] == dbc_pkg::DBC_B_WRITE)
                || (bst_q[i] == dbc_pkg::DBC_B_READ_AC);
        end
    end
    assign all_idle_d = &idle_d;

    // Per-bank legality against the addressed bank's own state; refresh, mode set and all-bank close check every bank
    always_comb begin
        for (int i = 0; i < dbc_pkg::NUM_BANKS; i++) begin
            logic hit;
            logic pc_hit;
            hit = (pin_q.bank_addr == i[dbc_pkg::BA_W-1:0]);
            pc_hit = (cmd_d == dbc_pkg::DBC_CMD_PAGE_CLOSE) && (hit || pin_q.auto_close);
            bank_bad_d[i] = 1'b0;
            if (normal_d && !is_nop) begin
                case (bst_q[i])
                    dbc_pkg::DBC_B_IDLE:
                        bank_bad_d[i] = hit && ((cmd_d == dbc_pkg::DBC_CMD_READ)
                            || (cmd_d == dbc_pkg::DBC_CMD_WRITE)
                            || (cmd_d == dbc_pkg::DBC_CMD_RESERVED));
                    dbc_pkg::DBC_B_ACTIVE:
                        bank_bad_d[i] = hit && ((cmd_d == dbc_pkg::DBC_CMD_ACTIVATE)
                            || (cmd_d == dbc_pkg::DBC_CMD_RESERVED));
                    dbc_pkg::DBC_B_PAGE_CLOSING:
                        bank_bad_d[i] = hit && (cmd_d != dbc_pkg::DBC_CMD_PAGE_CLOSE);
                    dbc_pkg::DBC_B_WRITE_RECOVER:
                        bank_bad_d[i] = (hit && (cmd_d != dbc_pkg::DBC_CMD_WRITE)) || pc_hit;
                    default: // and bursting banks
                        bank_bad_d[i] = hit || pc_hit;
                endcase
            end
            if (normal_d && ((cmd_d == dbc_pkg::DBC_CMD_REFRESH)
                || (cmd_d == dbc_pkg::DBC_CMD_MODE_SET)) && !idle_d[i]) begin
                bank_bad_d[i] = 1'b1;
            end
        end
    end

    // Bank states; timers count down and the state moves when they reach one
    always_ff @(posedge core_clk_in) begin
        for (int i = 0; i < dbc_pkg::NUM_BANKS; i++) begin
            logic hit;
            logic done;
            hit = (pin_q.bank_addr == i[dbc_pkg::BA_W-1:0]);
            done = (bcnt_q[i] <= dbc_pkg::C_ONE);
            if (sys_rst_in) begin
                bst_q[i] <= dbc_pkg::DBC_B_IDLE;
                bcnt_q[i] <= dbc_pkg::C_ZERO;
            end else begin
                if (!done) begin
                    bcnt_q[i] <= bcnt_q[i] - dbc_pkg::C_ONE;
                end
                case (bst_q[i])
                    dbc_pkg::DBC_B_IDLE:
                        if (normal_d && hit && (cmd_d == dbc_pkg::DBC_CMD_ACTIVATE)) begin
                            bst_q[i] <= dbc_pkg::DBC_B_ACTIVATING;
                            bcnt_q[i] <= dbc_pkg::C_ACT_TO_COL;
                        end
                    dbc_pkg::DBC_B_ACTIVATING:
                        if (done) begin
                            bst_q[i] <= dbc_pkg::DBC_B_ACTIVE;
                        end
                    dbc_pkg::DBC_B_ACTIVE, dbc_pkg::DBC_B_WRITE_RECOVER:
                        if (normal_d && (cmd_d == dbc_pkg::DBC_CMD_PAGE_CLOSE)
                            && (hit || pin_q.auto_close)) begin
                            bst_q[i] <= dbc_pkg::DBC_B_PAGE_CLOSING;
                            bcnt_q[i] <= dbc_pkg::C_PAGE_CLOSE;
                        end else if (normal_d && hit && (cmd_d == dbc_pkg::DBC_CMD_READ)
                            && (bst_q[i] == dbc_pkg::DBC_B_ACTIVE)) begin
                            bst_q[i] <= pin_q.auto_close ? dbc_pkg::DBC_B_READ_AC
                                : dbc_pkg::DBC_B_READ;
                            bcnt_q[i] <= dbc_pkg::C_BURST;
                        end else if (normal_d && hit && (cmd_d == dbc_pkg::DBC_CMD_WRITE)) begin
                            // New write restarts the burst and re-samples auto_close
                            bst_q[i] <= dbc_pkg::DBC_B_WRITE;
                            bcnt_q[i] <= dbc_pkg::C_BURST;
                        end else if ((bst_q[i] == dbc_pkg::DBC_B_WRITE_RECOVER) && done) begin
                            bst_q[i] <= dbc_pkg::DBC_B_ACTIVE;
                        end
                    dbc_pkg::DBC_B_READ:
                        if (done) begin
                            bst_q[i] <= dbc_pkg::DBC_B_ACTIVE;
                        end
                    dbc_pkg::DBC_B_READ_AC:
                        if (done) begin
                            bst_q[i] <= dbc_pkg::DBC_B_PAGE_CLOSING;
                            bcnt_q[i] <= dbc_pkg::C_PAGE_CLOSE;
                        end
                    dbc_pkg::DBC_B_WRITE:
                        if (done) begin
                            bst_q[i] <= wr_ac_q[i] ? dbc_pkg::DBC_B_WRITE_AC_RECOVER
                                : dbc_pkg::DBC_B_WRITE_RECOVER;
                            bcnt_q[i] <= wr_ac_q[i] ? dbc_pkg::C_WRITE_AC_RECOVER
                                : dbc_pkg::C_WRITE_RECOVER;
                        end
                    dbc_pkg::DBC_B_WRITE_AC_RECOVER:
                        if (done) begin
                            bst_q[i] <= dbc_pkg::DBC_B_IDLE;
                        end
                    dbc_pkg::DBC_B_PAGE_CLOSING:
                        if (done) begin
                            bst_q[i] <= dbc_pkg::DBC_B_IDLE;
                        end
                    default:
                        bst_q[i] <= dbc_pkg::DBC_B_IDLE;
                endcase
            end
        end
    end

    // Auto-close flag of the latest write, per bank
    always_ff @(posedge core_clk_in) begin
        for (int i = 0; i < dbc_pkg::NUM_BANKS; i++) begin
            if (sys_rst_in) begin
                wr_ac_q[i] <= 1'b0;
            end else if (normal_d && (cmd_d == dbc_pkg::DBC_CMD_WRITE)
                && (pin_q.bank_addr == i[dbc_pkg::BA_W-1:0])) begin
                wr_ac_q[i] <= pin_q.auto_close;
            end
        end
    end

    // Power and whole-device state
    always_comb begin
        pwr_bad_d = 1'b0;
        case (pst_q)
            dbc_pkg::DBC_P_NORMAL:
                if (pd_prev_q && !pin_q.power_down_n) begin
                    // Entry only from all idle; a busy bank means a suspend attempt
                    pwr_bad_d = !all_idle_d || !(is_nop
                        || (cmd_d == dbc_pkg::DBC_CMD_REFRESH));
                end
            dbc_pkg::DBC_P_REFRESHING, dbc_pkg::DBC_P_MODE_SETTING:
                pwr_bad_d = !is_nop || !pin_q.power_down_n;
            dbc_pkg::DBC_P_POWER_DOWN, dbc_pkg::DBC_P_SELF_REFRESH:
                pwr_bad_d = pin_q.power_down_n && !is_nop;
            dbc_pkg::DBC_P_PD_EXIT, dbc_pkg::DBC_P_SR_RECOVERY:
                pwr_bad_d = !is_nop || !pin_q.power_down_n;
            default:
                pwr_bad_d = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            pst_q <= dbc_pkg::DBC_P_NORMAL;
            pcnt_q <= dbc_pkg::C_ZERO;
        end else begin
            if (pcnt_q > dbc_pkg::C_ONE) begin
                pcnt_q <= pcnt_q - dbc_pkg::C_ONE;
            end
            case (pst_q)
                dbc_pkg::DBC_P_NORMAL:
                    if (all_idle_d && pd_prev_q && !pin_q.power_down_n) begin
                        if (is_nop) begin
                            pst_q <= dbc_pkg::DBC_P_POWER_DOWN;
                        end else if (cmd_d == dbc_pkg::DBC_CMD_REFRESH) begin
                            pst_q <= dbc_pkg::DBC_P_SELF_REFRESH;
                        end
                    end else if (normal_d && all_idle_d) begin
                        if (cmd_d == dbc_pkg::DBC_CMD_REFRESH) begin
                            pst_q <= dbc_pkg::DBC_P_REFRESHING;
                            pcnt_q <= dbc_pkg::C_REFRESH_CYCLE;
                        end else if (cmd_d == dbc_pkg::DBC_CMD_MODE_SET) begin
                            pst_q <= dbc_pkg::DBC_P_MODE_SETTING;
                            pcnt_q <= dbc_pkg::C_MODE_SET_RECOVER;
                        end
                    end
                dbc_pkg::DBC_P_REFRESHING, dbc_pkg::DBC_P_MODE_SETTING,
                dbc_pkg::DBC_P_PD_EXIT, dbc_pkg::DBC_P_SR_RECOVERY:
                    if (pcnt_q <= dbc_pkg::C_ONE) begin
                        pst_q <= dbc_pkg::DBC_P_NORMAL;
                    end
                dbc_pkg::DBC_P_POWER_DOWN:
                    if (pin_q.power_down_n && is_nop) begin
                        pst_q <= dbc_pkg::DBC_P_PD_EXIT;
                        pcnt_q <= dbc_pkg::C_POWERDOWN_EXIT;
                    end
                dbc_pkg::DBC_P_SELF_REFRESH:
                    if (pin_q.power_down_n && is_nop) begin
                        pst_q <= dbc_pkg::DBC_P_SR_RECOVERY;
                        pcnt_q <= dbc_pkg::C_LOCK;
                    end
                default:
                    pst_q <= dbc_pkg::DBC_P_NORMAL;
            endcase
        end
    end

    // Registered status; illegal is a one-cycle pulse per offending edge
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            bank_idle_out <= '1;
            bank_open_out <= '0;
            bank_burst_out <= '0;
            all_idle_out <= 1'b1;
            power_down_out <= 1'b0;
            self_refresh_out <= 1'b0;
            dq_both_edges_out <= 1'b0;
            illegal_out <= 1'b0;
        end else begin
            bank_idle_out <= idle_d;
            for (int i = 0; i < dbc_pkg::NUM_BANKS; i++) begin
                bank_open_out[i] <= (bst_q[i] == dbc_pkg::DBC_B_ACTIVE);
            end
            bank_burst_out <= burst_d;
            all_idle_out <= all_idle_d && (pst_q == dbc_pkg::DBC_P_NORMAL);
            power_down_out <= (pst_q == dbc_pkg::DBC_P_POWER_DOWN);
            self_refresh_out <= (pst_q == dbc_pkg::DBC_P_SELF_REFRESH);
            dq_both_edges_out <= |burst_d;
            illegal_out <= (|bank_bad_d) || pwr_bad_d;
        end
    end
endmodule
`default_nettype wire

// [dv/dbc_bank_fsm_asserts.sv]
// Checker: bank and power state relations seen at the machine's ports.
`default_nettype none
module dbc_bank_fsm_chk (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire dbc_pkg::dbc_cmd_pins_t cmd_pins_in,
    input wire logic [7:0] bank_idle_out,
    input wire logic [7:0] bank_open_out,
    input wire logic [7:0] bank_burst_out,
    input wire logic all_idle_out,
    input wire logic power_down_out,
    input wire logic self_refresh_out,
    input wire logic dq_both_edges_out,
    input wire logic illegal_out
);
    logic [3:0] cmd_n;
    assign cmd_n = {cmd_pins_in.cs_n, cmd_pins_in.ras_n, cmd_pins_in.cas_n, cmd_pins_in.we_n};
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (sys_rst_in);
    a_idle_open_excl: assert property ((bank_idle_out & bank_open_out) == 8'h00)
        else $error("bank idle and open together");
    a_burst_dq_edges: assert property (|bank_burst_out |-> ##[0:1] dq_both_edges_out)
        else $error("burst without both-edge data");
    a_all_idle_sum: assert property (all_idle_out |->
        &bank_idle_out && !power_down_out && !self_refresh_out) else $error("idle sum wrong");
    // Reserved encoding with pd held high is never a legal command, whatever the state
    a_reserved_flag: assert property ($past(cmd_pins_in.power_down_n) &&
        cmd_pins_in.power_down_n && cmd_n == 4'h6 |-> ##3 illegal_out)
        else $error("reserved encoding not flagged");
    for (genvar i = 0; i < 8; i++) begin : g_bank
        a_act_hold_closed: assert property ($fell(bank_idle_out[i]) |->
            !bank_open_out[i] [*3]) else $error("bank open before activate delay");
        a_close_via_page: assert property ($rose(bank_idle_out[i]) |->
            !$past(bank_open_out[i]) && !$past(bank_burst_out[i]))
            else $error("bank idle without page close");
    end
    a_pd_exit_time: assert property ($fell(power_down_out) |->
        !all_idle_out ##[1:4] all_idle_out) else $error("power-down exit timing");
    a_sr_lock_time: assert property ($fell(self_refresh_out) |->
        ##150 !all_idle_out ##[1:60] all_idle_out) else $error("self-refresh lock timing");
    a_pd_entry: assert property (all_idle_out && $past(cmd_pins_in.power_down_n) &&
        !cmd_pins_in.power_down_n && cmd_pins_in.cs_n |-> ##[3:5] power_down_out)
        else $error("power-down not entered");
    a_sr_entry: assert property (all_idle_out && $past(cmd_pins_in.power_down_n) &&
        !cmd_pins_in.power_down_n && cmd_n == 4'h1 |-> ##[3:5] self_refresh_out)
        else $error("self-refresh not entered");
endmodule
bind dbc_bank_fsm dbc_bank_fsm_chk u_chk (.core_clk_in, .sys_rst_in, .cmd_pins_in,
    .bank_idle_out, .bank_open_out, .bank_burst_out, .all_idle_out, .power_down_out,
    .self_refresh_out, .dq_both_edges_out, .illegal_out);
`default_nettype wire

// [dv/dbc_ctl_model.sv]
// Controller model: drives one encoded command, then deselect with pd held.
`default_nettype none
module dbc_ctl_model (
    input wire logic core_clk_in,
    output var dbc_pkg::dbc_cmd_pins_t cmd_pins_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial cmd_pins_out = '1;
    // Callers space commands; one test also lowers and raises pd while bank 0 is open
    task automatic send(input dbc_pkg::dbc_cmd_t c, input logic [2:0] ba,
        input logic ac, input logic pd);
        logic [3:0] e;
        e = 4'h8 - 4'(c); // Encoding order makes the strobes a plain subtraction
        @(posedge core_clk_in);
        cmd_pins_out <= {pd, e, ac, ba};
        @(posedge core_clk_in);
        // Released lines toggle so a stale value is never mistaken for a command
        cmd_pins_out <= {pd, 1'b1, ~e[2:0], ~ac, ~ba};
    endtask
endmodule
`default_nettype wire

// [dv/test_ddr_dram_bank_command_fsm.sv]
// Testbench: table of bank commands, then hand-made edge cases.
`default_nettype none
module test_ddr_dram_bank_command_fsm;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        dbc_pkg::dbc_cmd_t cmd;
        logic [2:0] ba;
        logic ac;
        logic [7:0] idle;
        logic [7:0] open;
        logic all;
    } dbc_row_t;
    logic core_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    dbc_pkg::dbc_cmd_pins_t pins;
    logic [7:0] idle_o, open_o, burst_o;
    logic all_o, pd_o, sr_o, dq_o, ill_o;
    int err_total = 0;
    int cmp_count = 0;
    int ill_cnt = 0;
    int n, m;
    dbc_row_t rows [13];
    initial begin
        forever #2.5 core_clk_in = ~core_clk_in;
    end
    dbc_bank_fsm uut (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .cmd_pins_in(pins),
        .bank_idle_out(idle_o), .bank_open_out(open_o), .bank_burst_out(burst_o),
        .all_idle_out(all_o), .power_down_out(pd_o), .self_refresh_out(sr_o),
        .dq_both_edges_out(dq_o), .illegal_out(ill_o));
    dbc_ctl_model ctl (.core_clk_in(core_clk_in), .cmd_pins_out(pins));
    always @(posedge core_clk_in) begin
        if (ill_o === 1'b1) ill_cnt++;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk_in);
        #1;
    endtask
    // Bounded wait, so a stuck machine ends as a mismatch rather than a hang
    task automatic idle_wait(input int lim);
        n = 0;
        while (all_o !== 1'b1 && n < lim) begin
            tick(1);
            n++;
        end
    endtask
    task automatic give_verdict;
        $display("mismatches %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        tick(4000);
        err_total++;
        give_verdict();
    end
    initial begin
        rows = '{
            '{dbc_pkg::DBC_CMD_ACTIVATE, 3'h0, 1'b0, 8'hfe, 8'h01, 1'b0},
            '{dbc_pkg::DBC_CMD_ACTIVATE, 3'h7, 1'b0, 8'h7e, 8'h81, 1'b0},
            '{dbc_pkg::DBC_CMD_WRITE, 3'h0, 1'b0, 8'h7e, 8'h81, 1'b0},
            '{dbc_pkg::DBC_CMD_READ, 3'h7, 1'b0, 8'h7e, 8'h81, 1'b0},
            '{dbc_pkg::DBC_CMD_PAGE_CLOSE, 3'h0, 1'b0, 8'h7f, 8'h80, 1'b0},
            '{dbc_pkg::DBC_CMD_READ, 3'h7, 1'b1, 8'hff, 8'h00, 1'b1},
            '{dbc_pkg::DBC_CMD_ACTIVATE, 3'h3, 1'b0, 8'hf7, 8'h08, 1'b0},
            '{dbc_pkg::DBC_CMD_WRITE, 3'h3, 1'b1, 8'hff, 8'h00, 1'b1},
            '{dbc_pkg::DBC_CMD_ACTIVATE, 3'h1, 1'b0, 8'hfd, 8'h02, 1'b0},
            '{dbc_pkg::DBC_CMD_ACTIVATE, 3'h5, 1'b0, 8'hdd, 8'h22, 1'b0},
            '{dbc_pkg::DBC_CMD_PAGE_CLOSE, 3'h0, 1'b1, 8'hff, 8'h00, 1'b1},
            '{dbc_pkg::DBC_CMD_REFRESH, 3'h0, 1'b0, 8'hff, 8'h00, 1'b1},
            '{dbc_pkg::DBC_CMD_MODE_SET, 3'h0, 1'b0, 8'hff, 8'h00, 1'b1}
        };
        tick(7);
        check(idle_o, 8'hff);
        check({open_o | burst_o}, 8'h00);
        check({all_o, pd_o, sr_o, dq_o, ill_o, 3'h0}, 8'h80);
        @(posedge core_clk_in);
        sys_rst_in <= 1'b0;
        for (int i = 0; i < 13; i++) begin
            m = ill_cnt;
            ctl.send(rows[i].cmd, rows[i].ba, rows[i].ac, 1'b1);
            tick(24);
            check(idle_o, rows[i].idle);
            check(open_o, rows[i].open);
            check(8'(all_o), 8'(rows[i].all));
            check(8'(ill_cnt - m), 8'h00);
        end
        // Second write lands while the first is still recovering
        ctl.send(dbc_pkg::DBC_CMD_ACTIVATE, 3'h2, 1'b0, 1'b1);
        tick(24);
        m = ill_cnt;
        ctl.send(dbc_pkg::DBC_CMD_WRITE, 3'h2, 1'b0, 1'b1);
        @(posedge core_clk_in);
        ctl.send(dbc_pkg::DBC_CMD_WRITE, 3'h2, 1'b1, 1'b1);
        n = 0;
        while (dq_o !== 1'b1 && n < 8) begin
            tick(1);
            n++;
        end
        check(8'(dq_o), 8'h01);
        check(burst_o, 8'h04);
        tick(24);
        check(idle_o, 8'hff);
        check(8'(ill_cnt - m), 8'h00);
        // Read to an idle bank while bank 5 is in its auto-close read burst
        ctl.send(dbc_pkg::DBC_CMD_ACTIVATE, 3'h4, 1'b0, 1'b1);
        ctl.send(dbc_pkg::DBC_CMD_ACTIVATE, 3'h5, 1'b0, 1'b1);
        tick(24);
        m = ill_cnt;
        ctl.send(dbc_pkg::DBC_CMD_READ, 3'h4, 1'b1, 1'b1);
        tick(2);
        ctl.send(dbc_pkg::DBC_CMD_READ, 3'h5, 1'b1, 1'b1);
        ctl.send(dbc_pkg::DBC_CMD_READ, 3'h6, 1'b0, 1'b1);
        tick(24);
        check(idle_o, 8'hff);
        check(8'(ill_cnt - m), 8'h01);
        // Repeats inside activating and refreshing
        m = ill_cnt;
        ctl.send(dbc_pkg::DBC_CMD_ACTIVATE, 3'h1, 1'b0, 1'b1);
        ctl.send(dbc_pkg::DBC_CMD_ACTIVATE, 3'h1, 1'b0, 1'b1);
        tick(24);
        ctl.send(dbc_pkg::DBC_CMD_PAGE_CLOSE, 3'h6, 1'b1, 1'b1);
        tick(24);
        ctl.send(dbc_pkg::DBC_CMD_REFRESH, 3'h0, 1'b0, 1'b1);
        ctl.send(dbc_pkg::DBC_CMD_REFRESH, 3'h0, 1'b0, 1'b1);
        tick(24);
        check(8'(ill_cnt - m), 8'h02);
        check(idle_o, 8'hff);
        // Power-down entry and exit with both idle encodings
        for (int k = 0; k < 2; k++) begin
            m = ill_cnt;
            ctl.send(k ? dbc_pkg::DBC_CMD_NOP : dbc_pkg::DBC_CMD_DESELECT, 3'h0, 1'b0, 1'b0);
            tick(6);
            check(8'(pd_o), 8'h01);
            ctl.send(k ? dbc_pkg::DBC_CMD_DESELECT : dbc_pkg::DBC_CMD_NOP, 3'h0, 1'b0, 1'b1);
            idle_wait(20);
            check({all_o, pd_o, 6'h00}, 8'h80);
            check(8'(ill_cnt - m), 8'h00);
        end
        // Self-refresh, with a stray read during lock recovery
        m = ill_cnt;
        ctl.send(dbc_pkg::DBC_CMD_REFRESH, 3'h0, 1'b0, 1'b0);
        tick(6);
        check(8'(sr_o), 8'h01);
        ctl.send(dbc_pkg::DBC_CMD_NOP, 3'h0, 1'b0, 1'b1);
        ctl.send(dbc_pkg::DBC_CMD_READ, 3'h0, 1'b0, 1'b1);
        idle_wait(400);
        check(8'(n >= dbc_pkg::C_LOCK - 8 && n <= dbc_pkg::C_LOCK + 8), 8'h01);
        check(8'(ill_cnt - m), 8'h01);
        // Lowering pd with a bank open is flagged; reserved encoding first
        ctl.send(dbc_pkg::DBC_CMD_ACTIVATE, 3'h0, 1'b0, 1'b1);
        tick(24);
        m = ill_cnt;
        ctl.send(dbc_pkg::DBC_CMD_RESERVED, 3'h0, 1'b0, 1'b1);
        tick(6);
        check(8'(ill_cnt - m), 8'h01);
        check(open_o, 8'h01);
        m = ill_cnt;
        ctl.send(dbc_pkg::DBC_CMD_DESELECT, 3'h0, 1'b0, 1'b0);
        tick(6);
        check(8'(ill_cnt != m), 8'h01);
        check(8'(pd_o), 8'h00);
        ctl.send(dbc_pkg::DBC_CMD_DESELECT, 3'h0, 1'b0, 1'b1);
        ctl.send(dbc_pkg::DBC_CMD_PAGE_CLOSE, 3'h0, 1'b1, 1'b1);
        tick(24);
        check(idle_o, 8'hff);
        // Power-down left with a read is flagged
        ctl.send(dbc_pkg::DBC_CMD_DESELECT, 3'h0, 1'b0, 1'b0);
        tick(6);
        m = ill_cnt;
        ctl.send(dbc_pkg::DBC_CMD_READ, 3'h0, 1'b0, 1'b1);
        tick(6);
        check(8'(ill_cnt != m), 8'h01);
        give_verdict();
    end
endmodule
`default_nettype wire
